/* verilog/prm_cfg.svh */
/*
 packet receive module configuration constants.
 assumes inclusion by the package, the top module and the bench.
*/
// What this block does
// R1 - busy sets when reception starts
// R2 - busy holds until buffers drained
// R3 - deserialize into buffer before memory write
// R4 - switch-off code finishes current reception
// R5 - trace packets up to 88 bits
// R6 - one-bit port: 91 interface clocks
// R7 - sixteen-bit port: 9 interface clocks
// R8 - software waits 95 clocks before reading busy
// R9 - port width selectable, one or sixteen
`ifndef PRM_CFG_SVH
`define PRM_CFG_SVH
`define PRM_PKT_BITS     88
`define PRM_PORT_W       16
`define PRM_SW_OFF       4'h5
`define PRM_SW_RST       4'hA
`define PRM_OVH_CLKS     3
`define PRM_W1_CLKS      91
`define PRM_W16_CLKS     9
`define PRM_SW_WAIT_CLKS 95
`define PRM_FIFO_DEPTH   32
`define PRM_BIT_CNT_W    7
`endif

/* verilog/prm_pkg.sv */
/*
 types of the packet receive module.
 assumes prm_cfg.svh is on the include path.
*/
`include "prm_cfg.svh"
package prm_pkg;
	typedef logic [`PRM_PKT_BITS-1:0] prm_pkt_t;
	typedef enum logic {PRM_W1, PRM_W16} prm_width_t;
	typedef enum logic [1:0] {PRM_IDLE, PRM_SHIFT, PRM_PAD, PRM_PUSH}
		prm_rx_state_t;
endpackage

/* verilog/prm_stream_if.sv */
/*
 valid/ready packet stream between receiver and fifo.
 assumes a single clock domain shared by both ends.
*/
interface prm_stream_if;
	import prm_pkg::*;
	logic     valid;
	logic     ready;
	prm_pkt_t data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* verilog/prm_fifo.sv */
/*
 packet fifo, parameter width and depth, valid/ready on both sides.
 assumes synchronous use on clock, reset active high async.
*/
module prm_fifo #(
	parameter int WIDTH = 88,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// fill side
	prm_stream_if.snk             wr,
	// drain side
	output logic                  rd_valid,
	output logic [WIDTH-1:0]      rd_data,
	input  wire logic             rd_ready,
	// state
	output logic                  empty
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_q;
	logic [AW:0]      wp_d;
	logic [AW:0]      rp_q;
	logic [AW:0]      rp_d;
	logic             full;
	logic             push;
	logic             pop;

	assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign empty = (wp_q == rp_q);
	assign wr.ready = !full;
	assign rd_valid = !empty;
	assign rd_data = mem[rp_q[AW-1:0]];
	assign push = wr.valid && !full;
	assign pop = rd_ready && !empty;

	always_comb begin
		wp_d = wp_q + (AW+1)'(push);
		rp_d = rp_q + (AW+1)'(pop);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= wr.data;
		end
	end
endmodule

/* verilog/prm_top.sv */
/*
 packet receive module: samples the interface clock, deserializes
 packets of 88 bits on a 1 or 16 bit port, buffers them, writes out.
 assumes link pins are asynchronous to clock; memory side is on clock.
*/
`include "prm_cfg.svh"
module prm_top (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               rst,
	// receiver global control
	input  wire logic [3:0]         power_switch,
	input  wire prm_pkg::prm_width_t port_width,
	output logic                    busy,
	output logic                    enabled,
	// external interface
	input  wire logic               receiver_interface_clock,
	input  wire logic               frame_sync,
	input  wire logic [15:0]        rx_data,
	// destination memory write
	output logic                    mem_wr_valid,
	output logic [87:0]             mem_wr_data,
	input  wire logic               mem_wr_ready,
	// diagnostics
	output logic                    pkt_done
);
	import prm_pkg::*;

	// two-stage synchronisers, third link clock stage for edge detect
	logic        clk_s1_q;
	logic        clk_s2_q;
	logic        clk_s3_q;
	logic        fs_s1_q;
	logic        fs_s2_q;
	logic [15:0] dat_s1_q;
	logic [15:0] dat_s2_q;
	logic        link_edge;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
			fs_s1_q  <= 1'b0;
			fs_s2_q  <= 1'b0;
			dat_s1_q <= 16'h0000;
			dat_s2_q <= 16'h0000;
		end else begin
			clk_s1_q <= receiver_interface_clock;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			fs_s1_q  <= frame_sync;
			fs_s2_q  <= fs_s1_q;
			dat_s1_q <= rx_data;
			dat_s2_q <= dat_s1_q;
		end
	end
	assign link_edge = clk_s2_q && !clk_s3_q;

	// enable from the power switch field
	logic en_q;
	logic en_d;
	always_comb begin
		en_d = en_q;
		if (power_switch == `PRM_SW_RST) begin
			en_d = 1'b1;
		end else if (power_switch == `PRM_SW_OFF) begin
			en_d = 1'b0;
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			en_q <= 1'b0;
		end else begin
			en_q <= en_d;
		end
	end

	function automatic logic [6:0] step_bits(prm_width_t w);
		return (w == PRM_W16) ? 7'd16 : 7'd1;
	endfunction

	// deserializer
	prm_stream_if    pkt_if ();
	prm_rx_state_t   st_q;
	prm_rx_state_t   st_d;
	prm_pkt_t        sh_q;
	prm_pkt_t        sh_d;
	logic [6:0]      cnt_q;
	logic [6:0]      cnt_d;
	prm_width_t      w_q;
	prm_width_t      w_d;
	logic            done_q;
	logic            done_d;
	logic            fifo_empty;
	logic [6:0]      step;
	logic [103:0]    wide;

	assign step = step_bits(w_q);
	assign pkt_if.valid = (st_q == PRM_PUSH);
	assign pkt_if.data = sh_q;

	always_comb begin
		st_d   = st_q;
		sh_d   = sh_q;
		cnt_d  = cnt_q;
		w_d    = w_q;
		done_d = 1'b0;
		wide   = {dat_s2_q, sh_q};
		unique case (st_q)
			PRM_IDLE: begin
				// R4 start only while enabled
				if (en_q && link_edge && fs_s2_q) begin
					w_d   = port_width;
					cnt_d = 7'd0;
					st_d  = PRM_SHIFT;
				end
			end
			// R9 shift by selected width
			// R5 88 bit packet
			PRM_SHIFT: begin
				if (link_edge) begin
					if (w_q == PRM_W16) begin
						sh_d = wide[103:16];
					end else begin
						sh_d = {dat_s2_q[0], sh_q[87:1]};
					end
					cnt_d = cnt_q + step;
					if (cnt_q + step >= 7'(`PRM_PKT_BITS)) begin
						cnt_d = 7'd0;
						st_d  = PRM_PAD;
					end
				end
			end
			// R6 R7 trailing deserialize clocks
			PRM_PAD: begin
				if (link_edge) begin
					cnt_d = cnt_q + 7'd1;
					if (cnt_q == 7'(`PRM_OVH_CLKS - 1)) begin
						st_d = PRM_PUSH;
					end
				end
			end
			// R3 into buffer first
			PRM_PUSH: begin
				if (pkt_if.ready) begin
					done_d = 1'b1;
					st_d   = PRM_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q   <= PRM_IDLE;
			sh_q   <= '0;
			cnt_q  <= 7'd0;
			w_q    <= PRM_W1;
			done_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			sh_q   <= sh_d;
			cnt_q  <= cnt_d;
			w_q    <= w_d;
			done_q <= done_d;
		end
	end

	logic     f_valid;
	prm_pkt_t f_data;
	logic     f_ready;

	prm_fifo #(
		.WIDTH(`PRM_PKT_BITS),
		.DEPTH(`PRM_FIFO_DEPTH)
	) u_fifo (
		.clock    (clock),
		.rst      (rst),
		.wr       (pkt_if),
		.rd_valid (f_valid),
		.rd_data  (f_data),
		.rd_ready (f_ready),
		.empty    (fifo_empty)
	);

	// registered memory write stage
	logic     mv_q;
	logic     mv_d;
	prm_pkt_t md_q;
	prm_pkt_t md_d;
	logic     busy_q;
	logic     busy_d;
	assign f_ready = !mv_q || mem_wr_ready;

	always_comb begin
		mv_d = mv_q;
		md_d = md_q;
		if (f_ready) begin
			mv_d = f_valid;
			if (f_valid) begin
				md_d = f_data;
			end
		end
		// R1 busy from reception start
		// R2 busy until drained
		busy_d = (st_d != PRM_IDLE) || (st_q != PRM_IDLE) ||
			!fifo_empty || mv_d;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mv_q   <= 1'b0;
			md_q   <= '0;
			busy_q <= 1'b0;
		end else begin
			mv_q   <= mv_d;
			md_q   <= md_d;
			busy_q <= busy_d;
		end
	end

	assign busy = busy_q;
	assign enabled = en_q;
	assign mem_wr_valid = mv_q;
	assign mem_wr_data = md_q;
	assign pkt_done = done_q;
endmodule

/* verif/prm_top_checker.sv */
/* port checker for prm_top.
 assumes a bind from the bench top. */
module prm_top_checker (
	// clock and reset
	input wire logic	clock,
	input wire logic	rst,
	// control
	input wire logic [3:0]	power_switch,
	input wire prm_pkg::prm_width_t	port_width,
	input wire logic	busy,
	input wire logic	enabled,
	// link
	input wire logic	receiver_interface_clock,
	input wire logic	frame_sync,
	input wire logic [15:0]	rx_data,
	// memory side
	input wire logic	mem_wr_valid,
	input wire logic [87:0]	mem_wr_data,
	input wire logic	mem_wr_ready,
	input wire logic	pkt_done
);
	timeunit 1ns;
	timeprecision 1ps;
	import prm_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_stall;
		mem_wr_valid && !mem_wr_ready;
	endsequence
	chk_valid_hold: assert property (
		s_stall |=> mem_wr_valid && $stable(mem_wr_data))
		else $error("write dropped");
	chk_write_busy: assert property (
		mem_wr_valid |-> busy) else $error("busy low in write");
	chk_busy_early: assert property (
		pkt_done |-> $past(busy, 8)) else $error("busy late");
	chk_done_pulse: assert property (
		pkt_done |=> !pkt_done) else $error("done too long");
	chk_on_code: assert property (
		power_switch == 4'hA |-> ##[1:2] enabled) else $error("not on");
	chk_off_code: assert property (
		power_switch == 4'h5 |-> ##[1:2] !enabled) else $error("not off");
	chk_release_ack: assert property (
		$fell(mem_wr_valid) |-> $past(mem_wr_ready))
		else $error("write lost");
	chk_busy_fall: assert property (
		$fell(busy) |-> !mem_wr_valid) else $error("busy fell early");
endmodule

/* verif/prm_link_model.sv */
/* link source model: framed link clock, sync and data.
 assumes the bench calls send only after the previous send has returned. */
module prm_link_model (
	// link pins
	output logic	lclk,
	output logic	fsync,
	output logic [15:0]	data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		lclk = 0;
		fsync = 0;
		data = 16'h0000;
	end
	task automatic send(input logic [87:0] p, input logic w16);
		logic [95:0] v;
		int n;
		v = w16 ? {p, 8'h00} : {8'h00, p};
		n = w16 ? 6 : 88;
		fsync = 1;
		#40 lclk = 1;
		#40 lclk = 0;
		fsync = 0;
		for (int i = 0; i < n + 3; i++) begin
			data = i >= n ? ~data : w16 ? v[16*i+:16] : {15'h0000, v[i]};
			#40 lclk = 1;
			#40 lclk = 0;
		end
		data = ~data;
	endtask
endmodule

/* verif/test_prm_top.sv */
/* self-checking bench for prm_top.
 assumes the link model and checker are compiled first. */
`include "prm_cfg.svh"
module test_prm_top;
	timeunit 1ns;
	timeprecision 1ps;
	import prm_pkg::*;
	// 80 ns link period on the 10 ns clock
	localparam int LCLK_CYC = 8;
	// sync lead before the first link edge, latency after the last
	localparam int LEAD = 4;
	localparam int LAT = 4;
	logic	clock = 0;
	logic	rst = 1;
	logic	mem_wr_ready = 0;
	logic [3:0]	power_switch = 4'h0;
	prm_width_t	port_width = PRM_W1;
	logic	busy, enabled, lclk, fs, mem_wr_valid, pkt_done;
	logic [15:0]	rxd;
	logic [87:0]	mem_wr_data;
	int	error_cnt = 0;
	int	n_compared = 0;
	always #5 clock = ~clock;
	prm_link_model u_src (.lclk(lclk), .fsync(fs), .data(rxd));
	prm_top u_dut (.clock(clock), .rst(rst), .power_switch(power_switch),
		.port_width(port_width), .busy(busy), .enabled(enabled),
		.receiver_interface_clock(lclk), .frame_sync(fs), .rx_data(rxd),
		.mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data),
		.mem_wr_ready(mem_wr_ready), .pkt_done(pkt_done));
	task automatic print_verdict;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk_data(input logic [87:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t data mismatch", $time);
		end
	endtask
	task automatic chk_bit(input logic got, exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t flag mismatch", $time);
		end
	endtask
	task automatic chk_cnt(input int got, lo, hi);
		n_compared++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("[FAIL] %0t cycle count %0d", $time, got);
		end
	endtask
	task automatic count_to_done(output int n);
		n = 0;
		while (pkt_done !== 1'b1 && n < 3000) begin
			@(negedge clock);
			n++;
		end
		if (n == 3000) begin
			error_cnt++;
			print_verdict;
		end
	endtask
	task automatic wait_for(ref logic sig, input logic val, input int lim);
		int i;
		for (i = 0; i < lim && sig !== val; i++)
			@(negedge clock);
		if (i == lim) begin
			error_cnt++;
			print_verdict;
		end
	endtask
	task automatic drain(input logic [87:0] exp);
		@(negedge clock);
		wait_for(mem_wr_valid, 1'b1, 3000);
		chk_data(mem_wr_data, exp);
		mem_wr_ready = 1;
		@(negedge clock);
		mem_wr_ready = 0;
	endtask
	task automatic s_widths;
		logic [87:0] p;
		int n;
		int clks;
		for (int w = 0; w < 2; w++) begin
			p = {11{8'hA5}} ^ {87'h0, w[0]};
			port_width = prm_width_t'(w[0]);
			fork
				u_src.send(p, w[0]);
			join_none
			repeat (12) @(negedge clock);
			chk_bit(busy, 1'b1);
			count_to_done(n);
			clks = w[0] ? `PRM_W16_CLKS : `PRM_W1_CLKS;
			// counted from the twelfth clock after frame start
			chk_cnt(n, LEAD + clks * LCLK_CYC + LAT - 13,
				LEAD + clks * LCLK_CYC + LAT - 11);
			drain(p);
			wait_for(busy, 1'b0, 50);
			chk_bit(busy, 1'b0);
		end
	endtask
	task automatic s_fill;
		port_width = PRM_W16;
		for (int k = 0; k < 33; k++) begin
			u_src.send({11{8'(k)}}, 1'b1);
			#100;
		end
		for (int k = 0; k < 33; k++)
			drain({11{8'(k)}});
		wait_for(busy, 1'b0, 50);
		chk_bit(busy, 1'b0);
	endtask
	task automatic s_switch_off;
		port_width = PRM_W1;
		fork
			u_src.send({11{8'h3C}}, 1'b0);
		join_none
		repeat (20) @(negedge clock);
		power_switch = 4'h5;
		repeat (`PRM_SW_WAIT_CLKS * LCLK_CYC) @(negedge clock);
		chk_bit(busy, 1'b1);
		chk_bit(enabled, 1'b0);
		drain({11{8'h3C}});
		wait_for(busy, 1'b0, 50);
		chk_bit(busy, 1'b0);
		// a new frame while switched off is not taken
		port_width = PRM_W16;
		u_src.send({11{8'h5A}}, 1'b1);
		repeat (10) @(negedge clock);
		chk_bit(busy, 1'b0);
		chk_bit(mem_wr_valid, 1'b0);
	endtask
	initial begin
		repeat (10) @(negedge clock);
		rst = 0;
		power_switch = 4'hA;
		repeat (3) @(negedge clock);
		s_widths;
		s_fill;
		s_switch_off;
		print_verdict;
	end
endmodule
bind prm_top prm_top_checker u_chk (.clock(clock), .rst(rst),
	.power_switch(power_switch), .port_width(port_width), .busy(busy),
	.enabled(enabled), .receiver_interface_clock(receiver_interface_clock),
	.frame_sync(frame_sync), .rx_data(rx_data),
	.mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data),
	.mem_wr_ready(mem_wr_ready), .pkt_done(pkt_done));
